// File: logic/adcs_control.sv
`timescale 1ns/1ps
`include "adcs_cfg.svh"

module adcs_control (
	// Clock, reset and enable.
	input  wire logic                                   i_clk,
	input  wire logic                                   i_rst,
	input  wire logic                                   i_ce,
	// Chip standby.
	input  wire logic                                   i_stop_standby,
	// Analog inputs, digitised, channel 0 in the low bits.
	input  wire logic [`ADCS_NUM_CH*`ADCS_RES_W-1:0]    i_analog_inputs,
	// AXI4-Lite write address and data.
	input  wire logic                                   i_awvalid,
	output logic                                        o_awready,
	input  wire logic [`ADCS_ADDR_W-1:0]                i_awaddr,
	input  wire logic                                   i_wvalid,
	output logic                                        o_wready,
	input  wire logic [31:0]                            i_wdata,
	input  wire logic [3:0]                             i_wstrb,
	// AXI4-Lite write response.
	output logic                                        o_bvalid,
	input  wire logic                                   i_bready,
	output logic [1:0]                                  o_bresp,
	// AXI4-Lite read.
	input  wire logic                                   i_arvalid,
	output logic                                        o_arready,
	input  wire logic [`ADCS_ADDR_W-1:0]                i_araddr,
	output logic                                        o_rvalid,
	input  wire logic                                   i_rready,
	output logic [31:0]                                 o_rdata,
	output logic [1:0]                                  o_rresp,
	// Converter controls and status.
	output logic [3:0]                                  o_channel_select,
	output logic                                        o_analog_input_gate,
	output logic                                        o_ladder_connect,
	output logic                                        o_conv_busy_flag,
	output logic                                        o_end_of_conv_flag,
	output adcs_pkg::adcs_state_t                       o_state,
	output logic                                        o_conv_done_irq
);
	import adcs_pkg::*;

	adcs_main_t             r_reg;
	adcs_main_t             r_next;
	adcs_tmr_if             u_tif ();
	logic                   busy_now;
	logic                   wr_go;
	logic                   wr_one;
	logic                   tsel_ok;
	logic                   mode_ok;
	logic                   start_req;
	logic                   abort;
	logic                   fin;
	logic                   rd_clear;
	logic [`ADCS_RES_W-1:0] sample;
	logic [`ADCS_IDX_W-1:0] ar_idx;

	// Reset images of the two control registers, cut to their fields below.
	localparam logic [7:0] ctrl_one_rst = `ADCS_CTRL_ONE_RST;
	localparam logic [7:0] ctrl_two_rst = `ADCS_CTRL_TWO_RST;

	// ======================================================================
	// Conversion timer.
	adcs_timer u_timer (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.tmr   (u_tif.tmr)
	);

	// Length decode of the time-select field; reserved codes give zero.
	always_comb begin
		unique case (r_reg.tsel)
			3'h0:    u_tif.len = `ADCS_CYC_C0;
			3'h2:    u_tif.len = `ADCS_CYC_C2;
			3'h3:    u_tif.len = `ADCS_CYC_C3;
			3'h4:    u_tif.len = `ADCS_CYC_C4;
			3'h5:    u_tif.len = `ADCS_CYC_C5;
			3'h6:    u_tif.len = `ADCS_CYC_C6;
			default: u_tif.len = '0;
		endcase
	end

	// Timer commands come from flip-flops.
	assign u_tif.start = r_reg.tmr_start;
	assign u_tif.abort = r_reg.tmr_abort;

	// Selected input; a gated or reserved channel converts as zero.
	assign sample = (r_reg.gate || r_reg.chan[3]) ? '0 :
		i_analog_inputs[r_reg.chan[2:0]*`ADCS_RES_W +: `ADCS_RES_W];

	assign busy_now = (r_reg.state == ADCS_RUN);
	assign tsel_ok  = (u_tif.len != '0);
	assign ar_idx   = i_araddr[`ADCS_ADDR_W-1:2];

	// ======================================================================
	// Next state: bus slave, register writes and the conversion sequence.
	always_comb begin
		r_next    = r_reg;
		r_next.irq       = 1'b0;
		r_next.tmr_start = 1'b0;
		r_next.tmr_abort = 1'b0;
		rd_clear  = 1'b0;
		wr_go     = 1'b0;
		// Write address and data are taken independently.
		if (i_awvalid && r_reg.awrdy) begin
			r_next.aw_have = 1'b1;
			r_next.aw_idx  = i_awaddr[`ADCS_ADDR_W-1:2];
		end
		if (i_wvalid && r_reg.wrdy) begin
			r_next.w_have = 1'b1;
			r_next.wdata  = i_wdata[7:0];
			r_next.wstrb0 = i_wstrb[0];
		end
		if (r_reg.bvalid && i_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_next.aw_have && r_next.w_have && !r_next.bvalid) begin
			wr_go          = 1'b1;
			r_next.aw_have = 1'b0;
			r_next.w_have  = 1'b0;
			r_next.bvalid  = 1'b1;
			r_next.bresp   = (r_next.aw_idx >= `ADCS_IDX_CTRL_ONE &&
				r_next.aw_idx <= `ADCS_IDX_RES_HIGH) ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
		end
		// Read: one outstanding answer, data latched at acceptance.
		if (r_reg.rvalid && i_rready) begin
			r_next.rvalid = 1'b0;
		end
		if (i_arvalid && r_reg.arrdy) begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = `ADCS_RESP_OKAY;
			unique case (ar_idx)
				`ADCS_IDX_CTRL_ONE: r_next.rdata = {1'b0, r_reg.mode, r_reg.gate, r_reg.chan};
				`ADCS_IDX_CTRL_TWO: r_next.rdata = {2'b00, r_reg.ladder, 1'b1, r_reg.tsel, 1'b0};
				`ADCS_IDX_RES_LOW:  r_next.rdata = {r_reg.result[1:0], r_reg.eoc, r_reg.busy,
					4'h0};
				`ADCS_IDX_RES_HIGH: begin
					r_next.rdata = r_reg.result[`ADCS_RES_W-1:2];
					rd_clear     = 1'b1;
				end
				default: begin
					r_next.rdata = 8'h00;
					r_next.rresp = `ADCS_RESP_SLVERR;
				end
			endcase
		end
		// Decode of the control-one write.
		wr_one    = wr_go && r_next.wstrb0 && !i_stop_standby &&
			(r_next.aw_idx == `ADCS_IDX_CTRL_ONE);
		mode_ok   = (r_next.wdata[`ADCS_MODE_HI:`ADCS_MODE_LO] == `ADCS_MODE_SINGLE) ||
			(r_next.wdata[`ADCS_MODE_HI:`ADCS_MODE_LO] == `ADCS_MODE_REPEAT);
		abort     = busy_now && wr_one &&
			(r_next.wdata[`ADCS_MODE_HI:`ADCS_MODE_LO] == `ADCS_MODE_OFF);
		start_req = wr_one && r_next.wdata[`ADCS_START_BIT] && mode_ok && tsel_ok &&
			!busy_now;
		fin       = busy_now && u_tif.done && !abort;
		// Reading the high result clears the flag; completion below wins.
		if (rd_clear) begin
			r_next.eoc = 1'b0;
		end
		if (fin) begin
			r_next.result = sample;
			r_next.eoc    = 1'b1;
			r_next.irq    = 1'b1;
			if (r_reg.mode == `ADCS_MODE_REPEAT) begin
				r_next.tmr_start = 1'b1;
			end else begin
				r_next.state = ADCS_IDLE;
			end
		end
		if (wr_one) begin
			r_next.mode = r_next.wdata[`ADCS_MODE_HI:`ADCS_MODE_LO];
			r_next.gate = r_next.wdata[`ADCS_GATE_BIT];
			r_next.chan = r_next.wdata[`ADCS_CHAN_HI:0];
		end
		if (wr_go && r_next.wstrb0 && !i_stop_standby &&
			(r_next.aw_idx == `ADCS_IDX_CTRL_TWO)) begin
			r_next.ladder = r_next.wdata[`ADCS_LADDER_BIT];
			r_next.tsel   = r_next.wdata[`ADCS_TSEL_HI:`ADCS_TSEL_LO];
		end
		// The start bit is never stored, so it reads back as zero.
		if (start_req) begin
			r_next.state     = ADCS_RUN;
			r_next.tmr_start = 1'b1;
			r_next.eoc       = 1'b0;
		end
		if (abort) begin
			r_next.state     = ADCS_IDLE;
			r_next.tmr_abort = 1'b1;
			r_next.tmr_start = 1'b0;
		end
		// Stop standby: abort, reload controls, drop results.
		if (i_stop_standby) begin
			r_next.state     = ADCS_IDLE;
			r_next.tmr_abort = 1'b1;
			r_next.tmr_start = 1'b0;
			r_next.irq       = 1'b0;
			r_next.eoc       = 1'b0;
			r_next.result    = '0;
			{r_next.mode, r_next.gate, r_next.chan} = ctrl_one_rst[6:0];
			r_next.ladder    = ctrl_two_rst[`ADCS_LADDER_BIT];
			r_next.tsel      = ctrl_two_rst[`ADCS_TSEL_HI:`ADCS_TSEL_LO];
		end
		r_next.busy       = (r_next.state == ADCS_RUN);
		r_next.ladder_out = !i_stop_standby && (r_next.ladder || r_next.busy);
		r_next.awrdy      = !r_next.aw_have && !r_next.bvalid;
		r_next.wrdy       = !r_next.w_have && !r_next.bvalid;
		r_next.arrdy      = !r_next.rvalid;
	end

	// Registers the whole state; the enable freezes it.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg        <= '0;
			r_reg.state  <= ADCS_IDLE;
			{r_reg.mode, r_reg.gate, r_reg.chan} <= ctrl_one_rst[6:0];
		end else if (i_ce) begin
			r_reg <= r_next;
		end
	end

	// ======================================================================
	// Outputs straight from the state flip-flops.
	assign o_awready           = r_reg.awrdy;
	assign o_wready            = r_reg.wrdy;
	assign o_bvalid            = r_reg.bvalid;
	assign o_bresp             = r_reg.bresp;
	assign o_arready           = r_reg.arrdy;
	assign o_rvalid            = r_reg.rvalid;
	assign o_rdata             = {24'h00_0000, r_reg.rdata};
	assign o_rresp             = r_reg.rresp;
	assign o_channel_select    = r_reg.chan;
	assign o_analog_input_gate = r_reg.gate;
	assign o_ladder_connect    = r_reg.ladder_out;
	assign o_conv_busy_flag    = r_reg.busy;
	assign o_end_of_conv_flag  = r_reg.eoc;
	assign o_state             = r_reg.state;
	assign o_conv_done_irq     = r_reg.irq;

	// ======================================================================
	// Cycle count of the running conversion, read only by assertions.
	logic [`ADCS_CNT_W:0] dbg_cnt;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dbg_cnt <= '0;
		end else if (i_ce) begin
			dbg_cnt <= r_reg.tmr_start ? (`ADCS_CNT_W+1)'(1) : dbg_cnt + 1'b1;
		end
	end

	// Remembers a repeat-mode completion until the sequencer goes idle.
	logic rep_seen;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rep_seen <= 1'b0;
		end else if (i_ce) begin
			if (fin && r_reg.mode == `ADCS_MODE_REPEAT) begin
				rep_seen <= 1'b1;
			end else if (!busy_now) begin
				rep_seen <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_conv_length: assert property (fin |-> dbg_cnt == {1'b0, u_tif.len})
		else $error("conversion ended at the wrong cycle");
	a_done_store: assert property (fin && !i_stop_standby && i_ce |=>
		o_conv_done_irq && o_end_of_conv_flag && r_reg.result == $past(sample))
		else $error("completion did not store result and raise flags");
	a_irq_pulse: assert property (o_conv_done_irq && i_ce |=> !o_conv_done_irq)
		else $error("done interrupt longer than one cycle");
	a_start_run: assert property (start_req && !i_stop_standby && i_ce |=>
		o_conv_busy_flag && !o_end_of_conv_flag ##1 !r_reg.tmr_start || !i_ce)
		else $error("start did not begin conversion");
	a_start_once: assert property (r_reg.tmr_start && !fin && i_ce |=> !r_reg.tmr_start)
		else $error("start held longer than one cycle");
	a_repeat_next: assert property (fin && r_reg.mode == `ADCS_MODE_REPEAT &&
		!i_stop_standby && !abort && i_ce |=> o_conv_busy_flag && r_reg.tmr_start)
		else $error("repeat mode did not restart");
	a_abort_drop: assert property (abort && !i_stop_standby && i_ce |=>
		!o_conv_busy_flag && !o_conv_done_irq && r_reg.result == $past(r_reg.result))
		else $error("abort stored a result or kept busy");
	a_bad_mode: assert property (wr_one && !mode_ok && !busy_now && i_ce |=>
		!o_conv_busy_flag)
		else $error("start in off or reserved mode began a conversion");
	a_read_clear: assert property (rd_clear && !fin && i_ce |=> !o_end_of_conv_flag)
		else $error("result read did not clear the end flag");
	a_stop_reset: assert property (i_stop_standby && i_ce |=> !o_conv_busy_flag &&
		!o_ladder_connect && r_reg.mode == `ADCS_MODE_OFF && r_reg.result == '0)
		else $error("stop standby left state behind");
	a_ladder_busy: assert property (o_conv_busy_flag |-> o_ladder_connect)
		else $error("ladder not connected while converting");
	a_no_resume: assert property ($fell(i_stop_standby) |-> !o_conv_busy_flag)
		else $error("conversion resumed after standby");
	a_no_self_start: assert property (!o_conv_busy_flag && !start_req && i_ce |=>
		!o_conv_busy_flag)
		else $error("conversion began without a software start");

	c_single_done: cover property (r_reg.mode == `ADCS_MODE_SINGLE && fin);
	c_repeat_two:  cover property (fin && rep_seen && r_reg.mode == `ADCS_MODE_REPEAT);
	c_abort:       cover property (abort);
	c_stop_busy:   cover property (i_stop_standby && busy_now);

endmodule : adcs_control

// File: logic/adcs_cfg.svh
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// ==========================================================================
// Register indices; byte address is four times the index.
`define ADCS_ADDR_W       12
`define ADCS_IDX_W        10
`define ADCS_IDX_CTRL_ONE 10'h026
`define ADCS_IDX_CTRL_TWO 10'h027
`define ADCS_IDX_RES_LOW  10'h028
`define ADCS_IDX_RES_HIGH 10'h029

// ==========================================================================
// Reset values and field positions.
`define ADCS_CTRL_ONE_RST 8'h10
`define ADCS_CTRL_TWO_RST 8'h10
`define ADCS_START_BIT    7
`define ADCS_MODE_HI      6
`define ADCS_MODE_LO      5
`define ADCS_GATE_BIT     4
`define ADCS_CHAN_HI      3
`define ADCS_LADDER_BIT   5
`define ADCS_TSEL_HI      3
`define ADCS_TSEL_LO      1

// ==========================================================================
// Mode codes, widths and bus responses.
`define ADCS_MODE_OFF     2'h0
`define ADCS_MODE_SINGLE  2'h1
`define ADCS_MODE_REPEAT  2'h3
`define ADCS_NUM_CH       8
`define ADCS_RES_W        10
`define ADCS_CNT_W        11
`define ADCS_RESP_OKAY    2'h0
`define ADCS_RESP_SLVERR  2'h2

// ==========================================================================
// Conversion lengths in system clock cycles.
`define ADCS_CYC_C0       11'h027
`define ADCS_CYC_C2       11'h04E
`define ADCS_CYC_C3       11'h09C
`define ADCS_CYC_C4       11'h138
`define ADCS_CYC_C5       11'h270
`define ADCS_CYC_C6       11'h4E0

`endif

// File: logic/adcs_pkg.sv
`include "adcs_cfg.svh"

package adcs_pkg;

	// ======================================================================
	// Sequencer states.
	typedef enum logic {ADCS_IDLE, ADCS_RUN} adcs_state_t;

	// ======================================================================
	// Full state of the control block.
	typedef struct packed {
		adcs_state_t              state;
		logic                     busy;
		logic [1:0]               mode;
		logic                     gate;
		logic [3:0]               chan;
		logic                     ladder;
		logic [2:0]               tsel;
		logic [`ADCS_RES_W-1:0]   result;
		logic                     eoc;
		logic                     irq;
		logic                     ladder_out;
		logic                     tmr_start;
		logic                     tmr_abort;
		logic                     aw_have;
		logic [`ADCS_IDX_W-1:0]   aw_idx;
		logic                     w_have;
		logic [7:0]               wdata;
		logic                     wstrb0;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     awrdy;
		logic                     wrdy;
		logic                     arrdy;
		logic                     rvalid;
		logic [7:0]               rdata;
		logic [1:0]               rresp;
	} adcs_main_t;

	// ======================================================================
	// State of the conversion timer.
	typedef struct packed {
		logic [`ADCS_CNT_W-1:0] cnt;
	} adcs_tmr_st_t;

endpackage : adcs_pkg

// File: logic/adcs_tmr_if.sv
`timescale 1ns/1ps
`include "adcs_cfg.svh"

// Carries start, abort and length to the timer and its completion back.
interface adcs_tmr_if;
	logic                   start;
	logic                   abort;
	logic [`ADCS_CNT_W-1:0] len;
	logic                   done;

	modport ctl (output start, output abort, output len, input done);
	modport tmr (input start, input abort, input len, output done);
endinterface : adcs_tmr_if

// File: logic/adcs_timer.sv
`timescale 1ns/1ps
`include "adcs_cfg.svh"

module adcs_timer (
	// Clock, reset and enable.
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Control side.
	adcs_tmr_if.tmr  tmr
);
	import adcs_pkg::*;

	adcs_tmr_st_t r_reg;
	adcs_tmr_st_t r_next;

	// ======================================================================
	// Count down the conversion length; completion on the last count.
	always_comb begin
		r_next = r_reg;
		if (tmr.abort) begin
			r_next.cnt = '0;
		end else if (tmr.start) begin
			r_next.cnt = tmr.len;
		end else if (r_reg.cnt != '0) begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
	end

	// The last count marks completion unless a restart or abort overrides it.
	assign tmr.done = (r_reg.cnt == `ADCS_CNT_W'(1)) && !tmr.abort && !tmr.start;

	// Registers the timer state.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg <= '0;
		end else if (i_ce) begin
			r_reg <= r_next;
		end
	end

	// ======================================================================
	a_abort_stops: assert property (@(posedge i_clk) disable iff (i_rst)
		tmr.abort && i_ce |=> r_reg.cnt == '0)
		else $error("timer kept counting after abort");

endmodule : adcs_timer

// File: verif/adcs_analog_model.sv
`timescale 1ns/1ps

// ==========
// Analog source
module adcs_analog_model (
	// Level of channel zero.
	input  wire logic [9:0]  i_base,
	// Digitised inputs, channel n in bits 10n+9 down to 10n.
	output logic      [79:0] o_inputs
);
	// Each channel sits 37 codes above the one below, so a wrong channel shows.
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			o_inputs[n*10 +: 10] = i_base + 10'(n * 10'h025);
		end
	end
endmodule : adcs_analog_model

// File: verif/tb.sv
`timescale 1ns/1ps
`include "adcs_cfg.svh"

// ==========
// Compare helper
`define CHK(got, exp) begin n_checks++; if (32'(got) !== 32'(exp)) begin n_mismatch++; \
	$display("BAD t=%0t got=%h exp=%h", $time, 32'(got), 32'(exp)); end end

module tb;
	import adcs_pkg::*;
	localparam logic [11:0] A_C1 = {`ADCS_IDX_CTRL_ONE, 2'b00};
	localparam logic [11:0] A_C2 = {`ADCS_IDX_CTRL_TWO, 2'b00};
	localparam logic [11:0] A_LO = {`ADCS_IDX_RES_LOW, 2'b00};
	localparam logic [11:0] A_HI = {`ADCS_IDX_RES_HIGH, 2'b00};
	logic i_clk = 1'b0, i_rst = 1'b1, stop = 1'b0, ce = 1'b1;
	logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] ws = 4'h0;
	logic [9:0] base = 10'h000;
	logic awr, wr_rdy, bv, arr, rv, gate, ladder, busy, eoc, irq, busy_q;
	logic [1:0] br, rr;
	logic [31:0] rdat;
	logic [3:0] ch_sel;
	logic [79:0] analog;
	adcs_state_t st;
	int n_mismatch = 0, n_checks = 0, cyc = 0, t_start = 0, n_irq = 0;
	int lens [8] = '{39, 0, 78, 156, 312, 624, 1248, 0};

	// Clock at 40 MHz.
	always #12.5 i_clk = ~i_clk;

	adcs_analog_model u_inputs (.i_base(base), .o_inputs(analog));

	adcs_control u_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_stop_standby(stop),
		.i_analog_inputs(analog),
		.i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
		.i_wvalid(wv), .o_wready(wr_rdy), .i_wdata(wd), .i_wstrb(ws),
		.o_bvalid(bv), .i_bready(brdy), .o_bresp(br),
		.i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
		.o_rvalid(rv), .i_rready(rrdy), .o_rdata(rdat), .o_rresp(rr),
		.o_channel_select(ch_sel), .o_analog_input_gate(gate),
		.o_ladder_connect(ladder), .o_conv_busy_flag(busy),
		.o_end_of_conv_flag(eoc), .o_state(st), .o_conv_done_irq(irq)
	);

	// Notes when busy rises and counts completion pulses.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		busy_q <= busy;
		if (busy === 1'b1 && busy_q !== 1'b1) t_start = cyc;
		if (irq === 1'b1) n_irq++;
	end

	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// Ends the run after a wait ran out.
	task automatic give_up;
		n_mismatch++;
		tally_and_finish();
	endtask : give_up

	// ==========
	// Bus cycles
	// Writes one byte; address and data are held until each is taken.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic aw_ok, w_ok;
		int k;
		@(posedge i_clk);
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awa <= a;
		wd <= {24'h00_0000, d};
		ws <= 4'hf;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		for (k = 0; k < 20 && !(aw_ok && w_ok); k++) begin
			@(posedge i_clk);
			if (awv && awr === 1'b1) begin
				aw_ok = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr_rdy === 1'b1) begin
				w_ok = 1'b1;
				wv <= 1'b0;
			end
		end
		for (k = 0; k < 20 && bv !== 1'b1; k++) @(posedge i_clk);
		if (bv !== 1'b1) give_up();
		`CHK(br, `ADCS_RESP_OKAY)
		brdy <= 1'b0;
	endtask : wr

	// Reads one word and its response.
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge i_clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		for (k = 0; k < 20 && !(arv && arr === 1'b1); k++) @(posedge i_clk);
		arv <= 1'b0;
		for (k = 0; k < 20 && rv !== 1'b1; k++) @(posedge i_clk);
		if (rv !== 1'b1) give_up();
		d = rdat;
		r = rr;
		rrdy <= 1'b0;
	endtask : rd

	// Reads a word and compares it.
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(d, e)
	endtask : chk_rd

	// Sets time, ladder and mode, then writes the start bit.
	task automatic start(input logic [3:0] ch, input logic [1:0] m, input logic [2:0] c,
		input logic lad);
		wr(A_C2, {2'b00, lad, 1'b1, c, 1'b0});
		wr(A_C1, {1'b0, m, 1'b0, ch});
		wr(A_C1, {1'b1, m, 1'b0, ch});
	endtask : start

	// Waits for a completion pulse and checks that it lasts one cycle.
	task automatic wait_irq(output int t);
		int k;
		for (k = 0; k < 1400 && irq !== 1'b1; k++) @(posedge i_clk);
		if (irq !== 1'b1) give_up();
		t = cyc;
		@(posedge i_clk);
		`CHK(irq, 1'b0)
	endtask : wait_irq

	// ==========
	// Scenarios
	// One single conversion for every legal time code.
	task automatic t_single;
		int c, t;
		logic [9:0] r;
		for (c = 0; c < 7; c++) begin
			if (c != 1) begin
				base <= 10'(c * 10'h040 + 10'h005);
				start(4'(c), 2'h1, 3'(c), 1'b0);
				`CHK(busy, 1'b1)
				`CHK(st, ADCS_RUN)
				`CHK(ch_sel, 4'(c))
				`CHK(gate, 1'b0)
				`CHK(ladder, 1'b1)
				chk_rd(A_C1, {1'b0, 2'h1, 1'b0, 4'(c)});
				wait_irq(t);
				`CHK(t - t_start, lens[c] + 1)
				`CHK(busy, 1'b0)
				`CHK(st, ADCS_IDLE)
				`CHK(ladder, 1'b0)
				`CHK(eoc, 1'b1)
				r = base + 10'(c * 10'h025);
				chk_rd(A_LO, {r[1:0], 1'b1, 1'b0, 4'h0});
				chk_rd(A_HI, r[9:2]);
				`CHK(eoc, 1'b0)
			end
		end
		$display("test single done");
	endtask : t_single

	// Starts with mode off, mode reserved and reserved time codes.
	task automatic t_refuse;
		logic [4:0] cases [4] = '{5'h00, 5'h10, 5'h09, 5'h0f};
		int i, n0;
		for (i = 0; i < 4; i++) begin
			n0 = n_irq;
			start(4'h3, cases[i][4:3], cases[i][2:0], 1'b0);
			`CHK(busy, 1'b0)
			repeat (60) @(posedge i_clk);
			`CHK(n_irq, n0)
		end
		$display("test refuse done");
	endtask : t_refuse

	// Repeat mode, then an abort by a mode-off write in mid conversion.
	task automatic t_repeat;
		int t1, t2, n0;
		logic [9:0] r;
		base <= 10'h100;
		start(4'h2, 2'h3, 3'h0, 1'b0);
		wait_irq(t1);
		wait_irq(t2);
		`CHK(t2 - t1, 40)
		`CHK(busy, 1'b1)
		r = base + 10'h04a;
		base <= 10'h200;
		wr(A_C1, {1'b0, 2'h0, 1'b0, 4'h2});
		`CHK(busy, 1'b0)
		n0 = n_irq;
		repeat (60) @(posedge i_clk);
		`CHK(n_irq, n0)
		chk_rd(A_HI, r[9:2]);
		$display("test repeat done");
	endtask : t_repeat

	// A restart before the result was read keeps the old result.
	task automatic t_reconv;
		int t;
		logic [9:0] ra, rb;
		base <= 10'h050;
		start(4'h5, 2'h1, 3'h0, 1'b0);
		wait_irq(t);
		ra = base + 10'h0b9;
		base <= 10'h3f0;
		start(4'h5, 2'h1, 3'h0, 1'b0);
		`CHK(eoc, 1'b0)
		chk_rd(A_HI, ra[9:2]);
		wait_irq(t);
		rb = base + 10'h0b9;
		chk_rd(A_HI, rb[9:2]);
		$display("test reconvert done");
	endtask : t_reconv

	// Gated input, with the clock enable dropped for 20 cycles mid conversion.
	task automatic t_freeze;
		int t, n0;
		base <= 10'h155;
		wr(A_C2, 8'h10);
		wr(A_C1, 8'h33);
		wr(A_C1, 8'hb3);
		`CHK(gate, 1'b1)
		repeat (10) @(posedge i_clk);
		ce <= 1'b0;
		n0 = n_irq;
		repeat (20) @(posedge i_clk);
		`CHK(busy, 1'b1)
		`CHK(n_irq, n0)
		ce <= 1'b1;
		wait_irq(t);
		`CHK(t - t_start, lens[0] + 21)
		chk_rd(A_LO, 32'h0000_0020);
		chk_rd(A_HI, 32'h0000_0000);
		$display("test freeze done");
	endtask : t_freeze

	// Stop standby in mid conversion, and an unmapped read.
	task automatic t_standby;
		int n0;
		logic [31:0] d;
		logic [1:0] r;
		wr(A_C2, 8'h38);
		`CHK(ladder, 1'b1)
		wr(A_C1, 8'h21);
		wr(A_C1, 8'ha1);
		repeat (50) @(posedge i_clk);
		stop <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK(busy, 1'b0)
		`CHK(ladder, 1'b0)
		`CHK(eoc, 1'b0)
		`CHK(gate, 1'b1)
		`CHK(ch_sel, 4'h0)
		stop <= 1'b0;
		chk_rd(A_C1, 32'h0000_0010);
		chk_rd(A_C2, 32'h0000_0010);
		chk_rd(A_HI, 32'h0000_0000);
		n0 = n_irq;
		repeat (400) @(posedge i_clk);
		`CHK(n_irq, n0)
		`CHK(busy, 1'b0)
		rd(12'h000, d, r);
		`CHK(r, `ADCS_RESP_SLVERR)
		`CHK(d, 32'h0000_0000)
		$display("test standby done");
	endtask : t_standby

	// Main sequence.
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		t_single();
		t_refuse();
		t_repeat();
		t_reconv();
		t_freeze();
		t_standby();
		tally_and_finish();
	end
endmodule : tb
